// file: rtl/bcdu_defs.svh
/*
  constants of the bcd adjust / decrement unit: offsets, opcodes, flag
  positions, reset values and cycle counts. uses no types from bcdu_pkg.
*/
`ifndef BCDU_DEFS_SVH
`define BCDU_DEFS_SVH

`define BCDU_OFF_CMD 12'h000
`define BCDU_OFF_STAT 12'h004
`define BCDU_OFF_FLAGS 12'h008
`define BCDU_OFF_SYM 12'h00C
`define BCDU_OFF_PEND 12'h010
`define BCDU_MEM_BASE 12'h400
`define BCDU_MEM_TOP 12'h7FF

`define BCDU_OP_DA_R 8'h40
`define BCDU_OP_DA_P 8'h41
`define BCDU_OP_DEC_R 8'h00
`define BCDU_OP_DEC_P 8'h01
`define BCDU_OP_WORD_MINUS_ONE_OP_R 8'h80
`define BCDU_OP_WORD_MINUS_ONE_OP_P 8'h81
`define BCDU_OP_DI 8'h8F

`define BCDU_FL_C 7
`define BCDU_FL_Z 6
`define BCDU_FL_S 5
`define BCDU_FL_V 4
`define BCDU_FL_D 3
`define BCDU_FL_H 2
`define BCDU_SYM_IE 0

`define BCDU_FLAGS_RST 8'h00
`define BCDU_SYM_RST 8'h00

`define BCDU_DA_LO 8'h06
`define BCDU_DA_HI 8'h60
`define BCDU_DA_SLO 8'hFA
`define BCDU_DA_SHI 8'hA0

`define BCDU_CYC_BYTE 4'h4
`define BCDU_CYC_WORD 4'h8
`define BCDU_CYC_DI 4'h4
`endif

// file: rtl/bcdu_pkg.sv
/*
  types of the bcd adjust / decrement unit.
  assumes nothing beyond a systemverilog compiler.
*/
package bcdu_pkg;
  typedef enum logic [2:0] {
    BCDU_K_NONE = 3'b000,
    BCDU_K_DA = 3'b001,
    BCDU_K_DEC = 3'b010,
    BCDU_K_WORD_MINUS_ONE_OP = 3'b011,
    BCDU_K_DI = 3'b100
  } bcdu_kind_e;
  typedef enum logic {
    BCDU_IDLE = 1'b0,
    BCDU_EXEC = 1'b1
  } bcdu_state_e;
endpackage : bcdu_pkg

// file: rtl/bcdu_alu_if.sv
/*
  link between the sequencer and the arithmetic unit.
  assumes bcdu_pkg is compiled first.
*/
`timescale 1ns/1ps
interface bcdu_alu_if;
  import bcdu_pkg::*;
  bcdu_kind_e kind;
  logic c_in;
  logic h_in;
  logic d_in;
  logic [15:0] opnd;
  logic [15:0] res;
  logic c_out;
  logic z_out;
  logic s_out;
  logic v_out;
  modport core (output kind, c_in, h_in, d_in, opnd,
    input res, c_out, z_out, s_out, v_out);
  modport alu (input kind, c_in, h_in, d_in, opnd,
    output res, c_out, z_out, s_out, v_out);
endinterface : bcdu_alu_if

// file: rtl/bcdu_alu.sv
/*
  combinational result and flag logic for decimal adjust, byte and word
  decrement. assumes the sequencer holds operands stable while it reads.
*/
`timescale 1ns/1ps
`include "bcdu_defs.svh"
module bcdu_alu
  import bcdu_pkg::*;
(
  // operands in, results out
  bcdu_alu_if.alu a
);
  // returns {carry out, correction}
  function automatic logic [8:0] bcdu_da_fix(input logic [7:0] v,
      input logic c, input logic h, input logic sub);
    logic [7:0] f;
    logic co;
    f = 8'h00;
    co = 1'b0;
    if (sub) begin
      // other nibble ranges are outside valid bcd, result left undefined
      if (h) f = `BCDU_DA_SLO;
      if (c) f = 8'(f + `BCDU_DA_SHI);
      co = c;
    end else begin
      if (c || v[7:4] > 4'h9 || (v[7:4] == 4'h9 && v[3:0] > 4'h9)) begin
        f = `BCDU_DA_HI;
        co = 1'b1;
      end
      if (h || v[3:0] > 4'h9) f = 8'(f + `BCDU_DA_LO);
    end
    return {co, f};
  endfunction : bcdu_da_fix

  logic [8:0] fix;
  logic [7:0] r8;
  logic [15:0] r16;

  always_comb begin
    fix = bcdu_da_fix(a.opnd[7:0], a.c_in, a.h_in, a.d_in);
    r8 = 8'h00;
    r16 = 16'h0000;
    a.c_out = 1'b0;
    a.v_out = 1'b0;
    unique case (a.kind)
      BCDU_K_DA: begin
        r8 = 8'(a.opnd[7:0] + fix[7:0]);
        a.c_out = fix[8];
      end
      BCDU_K_DEC: begin
        r8 = 8'(a.opnd[7:0] - 8'h01);
        a.v_out = (a.opnd[7:0] == 8'h80);
      end
      BCDU_K_WORD_MINUS_ONE_OP: begin
        r16 = 16'(a.opnd - 16'h0001);
        a.v_out = (a.opnd == 16'h8000);
      end
      BCDU_K_DI, BCDU_K_NONE: begin
      end
    endcase
    a.res = (a.kind == BCDU_K_WORD_MINUS_ONE_OP) ? r16 : {8'h00, r8};
    a.z_out = (a.kind == BCDU_K_WORD_MINUS_ONE_OP) ? (r16 == 16'h0000) : (r8 == 8'h00);
    a.s_out = (a.kind == BCDU_K_WORD_MINUS_ONE_OP) ? r16[15] : r8[7];
  end
endmodule : bcdu_alu

// file: rtl/bcdu_top.sv
/*
  bcd adjust / decrement unit: avalon-mm slave, 256-byte register file,
  instruction sequencer, condition flags, mode register, pending bits.
  assumes a synchronous avalon master on clk_sys and async irq_req pins.
*/
`timescale 1ns/1ps
`include "bcdu_defs.svh"
module bcdu_top
  import bcdu_pkg::*;
#(
  parameter int unsigned IRQ_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt side
  input wire logic [IRQ_W-1:0] irq_req,
  output logic irq_service
);
  function automatic bcdu_kind_e bcdu_decode(input logic [7:0] o);
    case (o)
      `BCDU_OP_DA_R, `BCDU_OP_DA_P: return BCDU_K_DA;
      `BCDU_OP_DEC_R, `BCDU_OP_DEC_P: return BCDU_K_DEC;
      `BCDU_OP_WORD_MINUS_ONE_OP_R, `BCDU_OP_WORD_MINUS_ONE_OP_P: return BCDU_K_WORD_MINUS_ONE_OP;
      `BCDU_OP_DI: return BCDU_K_DI;
      default: return BCDU_K_NONE;
    endcase
  endfunction : bcdu_decode

  function automatic logic [3:0] bcdu_len(input bcdu_kind_e k);
    case (k)
      BCDU_K_WORD_MINUS_ONE_OP: return `BCDU_CYC_WORD;
      BCDU_K_DI: return `BCDU_CYC_DI;
      default: return `BCDU_CYC_BYTE;
    endcase
  endfunction : bcdu_len

  bcdu_alu_if alu_if ();

  bcdu_alu u_alu (
    .a(alu_if.alu)
  );

  logic [7:0] mem [256];
  bcdu_state_e st, next_st;
  bcdu_kind_e kind, next_kind;
  logic [7:0] opc, next_opc;
  logic [7:0] dst, next_dst;
  logic [7:0] ea, next_ea;
  logic [3:0] cnt, next_cnt;
  logic [3:0] last_cyc, next_last_cyc;
  logic err, next_err;
  logic [7:0] flags, next_flags;
  logic [7:0] system_mode_control, next_sym;
  logic [IRQ_W-1:0] pend, next_pend;
  logic [IRQ_W-1:0] sync1, sync2, sync3;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic next_irq_service;

  logic busy, fin, req, stall, acc_w, start;
  logic [7:0] ea1, cur_byte;
  logic [7:0] mem_idx;
  logic in_mem;
  logic we0, we1;
  logic [7:0] wa0, wa1, wd0, wd1;

  always_comb begin
    busy = (st == BCDU_EXEC);
    fin = busy && (cnt == 4'(bcdu_len(kind) - 4'h1));
    req = avs_read || avs_write;
    // writes wait while an instruction runs; reads never wait for it
    stall = busy && avs_write;
    acc_w = avs_write && !avs_waitrequest;
    in_mem = (avs_address >= `BCDU_MEM_BASE) && (avs_address <= `BCDU_MEM_TOP);
    mem_idx = avs_address[9:2];
    start = acc_w && (avs_address == `BCDU_OFF_CMD) && (avs_byteenable[1:0] == 2'h3);
    ea1 = 8'(ea + 8'h01);
    cur_byte = mem[ea];
    alu_if.kind = kind;
    alu_if.c_in = flags[`BCDU_FL_C];
    alu_if.h_in = flags[`BCDU_FL_H];
    alu_if.d_in = flags[`BCDU_FL_D];
    alu_if.opnd = (kind == BCDU_K_WORD_MINUS_ONE_OP) ? {mem[ea], mem[ea1]} : {8'h00, cur_byte};
  end

  // sequencer
  always_comb begin
    next_st = st;
    next_kind = kind;
    next_opc = opc;
    next_dst = dst;
    next_ea = ea;
    next_cnt = cnt;
    next_last_cyc = last_cyc;
    next_err = err;
    unique case (st)
      BCDU_IDLE: begin
        if (start) begin
          next_opc = avs_writedata[7:0];
          next_dst = avs_writedata[15:8];
          next_kind = bcdu_decode(avs_writedata[7:0]);
          next_cnt = 4'h0;
          if (bcdu_decode(avs_writedata[7:0]) == BCDU_K_NONE) begin
            next_err = 1'b1;
          end else begin
            next_st = BCDU_EXEC;
          end
        end
      end
      BCDU_EXEC: begin
        next_cnt = 4'(cnt + 4'h1);
        if (cnt == 4'h0) begin
          // pointer forms fetch the target address first; DI has no operand byte
          next_ea = (opc[0] && kind != BCDU_K_DI) ? mem[dst] : dst;
          if (kind == BCDU_K_WORD_MINUS_ONE_OP) next_ea = {next_ea[7:1], 1'b0};
        end
        if (fin) begin
          next_st = BCDU_IDLE;
          next_last_cyc = bcdu_len(kind);
        end
      end
    endcase
    if (acc_w && avs_address == `BCDU_OFF_STAT && avs_byteenable[0] && avs_writedata[1]) begin
      next_err = 1'b0;
    end
    // an illegal opcode in the clearing cycle still sets the bit
    if (start && st == BCDU_IDLE && bcdu_decode(avs_writedata[7:0]) == BCDU_K_NONE) begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st <= BCDU_IDLE;
      kind <= BCDU_K_NONE;
      opc <= 8'h00;
      dst <= 8'h00;
      ea <= 8'h00;
      cnt <= 4'h0;
      last_cyc <= 4'h0;
      err <= 1'b0;
    end else begin
      st <= next_st;
      kind <= next_kind;
      opc <= next_opc;
      dst <= next_dst;
      ea <= next_ea;
      cnt <= next_cnt;
      last_cyc <= next_last_cyc;
      err <= next_err;
    end
  end

  // flags, mode, register file writes
  always_comb begin
    next_flags = flags;
    next_sym = system_mode_control;
    we0 = 1'b0;
    we1 = 1'b0;
    wa0 = ea;
    wa1 = ea1;
    wd0 = alu_if.res[7:0];
    wd1 = alu_if.res[7:0];
    if (fin) begin
      unique case (kind)
        BCDU_K_DA: begin
          we0 = 1'b1;
          // overflow is undefined here, so it is simply kept
          next_flags[`BCDU_FL_C] = alu_if.c_out;
          next_flags[`BCDU_FL_Z] = alu_if.z_out;
          next_flags[`BCDU_FL_S] = alu_if.s_out;
        end
        BCDU_K_DEC, BCDU_K_WORD_MINUS_ONE_OP: begin
          we0 = 1'b1;
          if (kind == BCDU_K_WORD_MINUS_ONE_OP) begin
            wd0 = alu_if.res[15:8];
            we1 = 1'b1;
          end
          next_flags[`BCDU_FL_Z] = alu_if.z_out;
          next_flags[`BCDU_FL_S] = alu_if.s_out;
          next_flags[`BCDU_FL_V] = alu_if.v_out;
        end
        BCDU_K_DI: next_sym[`BCDU_SYM_IE] = 1'b0;
        BCDU_K_NONE: begin
        end
      endcase
    end
    if (acc_w && avs_byteenable[0]) begin
      if (avs_address == `BCDU_OFF_FLAGS) next_flags = avs_writedata[7:0];
      if (avs_address == `BCDU_OFF_SYM) next_sym = avs_writedata[7:0];
      if (in_mem) begin
        we0 = 1'b1;
        wa0 = mem_idx;
        wd0 = avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags <= `BCDU_FLAGS_RST;
      system_mode_control <= `BCDU_SYM_RST;
    end else begin
      flags <= next_flags;
      system_mode_control <= next_sym;
    end
  end

  // data array, no reset on purpose
  always_ff @(posedge clk_sys) begin
    if (we0) mem[wa0] <= wd0;
    if (we1) mem[wa1] <= wd1;
  end

  // pending bits and service request
  always_comb begin
    next_pend = pend;
    if (acc_w && avs_address == `BCDU_OFF_PEND && avs_byteenable[0]) begin
      next_pend = pend & ~avs_writedata[IRQ_W-1:0];
    end
    next_pend = next_pend | (sync2 & ~sync3);
    next_irq_service = system_mode_control[`BCDU_SYM_IE] && (|pend);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      pend <= '0;
      irq_service <= 1'b0;
    end else begin
      sync1 <= irq_req;
      sync2 <= sync1;
      sync3 <= sync2;
      pend <= next_pend;
      irq_service <= next_irq_service;
    end
  end

  // bus answer: one wait cycle, read data registered with the answer
  always_comb begin
    next_waitrequest = !(req && avs_waitrequest && !stall);
    next_readdata = avs_readdata;
    if (req && avs_waitrequest && !stall) begin
      next_readdata = 32'h0000_0000;
      if (in_mem) next_readdata[7:0] = mem[mem_idx];
      unique case (avs_address)
        `BCDU_OFF_CMD: next_readdata[15:0] = {dst, opc};
        `BCDU_OFF_STAT: next_readdata[11:0] = {last_cyc, 6'h00, err, busy};
        `BCDU_OFF_FLAGS: next_readdata[7:0] = flags;
        `BCDU_OFF_SYM: next_readdata[7:0] = system_mode_control;
        `BCDU_OFF_PEND: next_readdata[IRQ_W-1:0] = pend;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= next_waitrequest;
      avs_readdata <= next_readdata;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  a_da_add_hi: assert property (fin && kind == BCDU_K_DA && !flags[`BCDU_FL_D]
    && !flags[`BCDU_FL_C] && !flags[`BCDU_FL_H] && cur_byte[7:4] > 4'h9
    && cur_byte[3:0] <= 4'h9 |=> mem[$past(ea)] == 8'($past(cur_byte) + 8'h60)
    && flags[`BCDU_FL_C])
    else $error("decimal adjust after add did not add 60");
  a_da_sub_fix: assert property (fin && kind == BCDU_K_DA && flags[`BCDU_FL_D]
    && flags[`BCDU_FL_C] && flags[`BCDU_FL_H]
    |=> mem[$past(ea)] == 8'($past(cur_byte) + 8'h9A) && flags[`BCDU_FL_C])
    else $error("decimal adjust after subtract did not add 9A");
  a_da_flag_set: assert property (fin && kind == BCDU_K_DA |=>
    flags[`BCDU_FL_Z] == (mem[$past(ea)] == 8'h00) && flags[`BCDU_FL_S] == mem[$past(ea)][7]
    && flags[3:2] == $past(flags[3:2]))
    else $error("decimal adjust flags wrong");
  a_byte_op_len: assert property (start && !busy
    && (bcdu_decode(avs_writedata[7:0]) == BCDU_K_DA
    || bcdu_decode(avs_writedata[7:0]) == BCDU_K_DEC) |=> busy [*4] ##1 !busy)
    else $error("byte instruction not four cycles");
  a_dec_ptr_val: assert property (fin && kind == BCDU_K_DEC |=>
    mem[$past(ea)] == 8'($past(cur_byte) - 8'h01))
    else $error("byte decrement result wrong");
  a_dec_flag_set: assert property (fin && kind == BCDU_K_DEC |=>
    flags[`BCDU_FL_C] == $past(flags[`BCDU_FL_C])
    && flags[`BCDU_FL_V] == ($past(cur_byte) == 8'h80))
    else $error("byte decrement flags wrong");
  a_word_minus_one_op_len: assert property (start && !busy
    && bcdu_decode(avs_writedata[7:0]) == BCDU_K_WORD_MINUS_ONE_OP |=> busy [*8] ##1 !busy)
    else $error("word decrement not eight cycles");
  a_word_minus_one_op_flag: assert property (fin && kind == BCDU_K_WORD_MINUS_ONE_OP |=>
    flags[`BCDU_FL_Z] == ($past(alu_if.opnd) == 16'h0001)
    && flags[`BCDU_FL_C] == $past(flags[`BCDU_FL_C]) && !ea[0])
    else $error("word decrement flags wrong");
  a_di_clears: assert property (start && !busy && avs_writedata[7:0] == `BCDU_OP_DI
    |-> ##5 !system_mode_control[`BCDU_SYM_IE] && flags == $past(flags, 5))
    else $error("interrupt mask all failed");
  a_no_service: assert property (!system_mode_control[`BCDU_SYM_IE] |=> !irq_service)
    else $error("service while disabled");
  a_ptr_fetch: assert property (busy && cnt == 4'h0 && opc[0]
    && (kind == BCDU_K_DA || kind == BCDU_K_DEC) |=> ea == $past(mem[dst]))
    else $error("pointer form used wrong address");

  c_da_sub: cover property (fin && kind == BCDU_K_DA && flags[`BCDU_FL_D]);
  c_word_minus_one_op_ptr: cover property (fin && kind == BCDU_K_WORD_MINUS_ONE_OP && opc[0]);
  c_di_run: cover property (fin && kind == BCDU_K_DI);
  c_pend_off: cover property (!system_mode_control[`BCDU_SYM_IE] && |(sync2 & ~sync3));
endmodule : bcdu_top

// file: tb/bcdu_tb_top.sv
/*
  self-checking bench of the bcd adjust / decrement unit, driven over avalon-mm.
  assumes bcdu_top, bcdu_pkg and bcdu_defs.svh from rtl/, one clock at 25 MHz.
*/
`timescale 1ns/1ps
`include "bcdu_defs.svh"
module bcdu_tb_top;
  import bcdu_pkg::*;
  typedef struct packed {logic [31:0] exp; logic [31:0] mask;} bcdu_note_s;
  localparam logic [31:0] FULL = 32'hFFFFFFFF;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [7:0] irq_req = 8'h00;
  logic irq_service;
  logic [7:0] dv [4] = '{8'h80, 8'h01, 8'h00, 8'h3C};
  logic [15:0] dw [4] = '{16'h8000, 16'h0001, 16'h0000, 16'h1234};
  bcdu_note_s notes[$];
  bcdu_note_s nb;
  int n_mismatch = 0;
  int num_checks = 0;
  integer seed = 32'hd9aa;

  always #20 clk_sys = ~clk_sys;

  bcdu_top #(.IRQ_W(8)) dut (
    .clk_sys(clk_sys),
    .rst(rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .irq_req(irq_req),
    .irq_service(irq_service)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // request held until the edge where waitrequest is seen low; one idle edge after
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 40) n_mismatch++;
    @(posedge clk_sys);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  // mask of zero marks a poll whose data is not judged
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    notes.push_back('{e, m});
    bus(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic exec(input logic [7:0] op, input logic [7:0] r, input logic [3:0] cyc);
    logic [31:0] q;
    int n;
    wr(`BCDU_OFF_CMD, {16'h0, r, op});
    q = 32'h1;
    n = 0;
    while (q[0] !== 1'b0 && n < 30) begin
      notes.push_back('{32'h0, 32'h0});
      bus(1'b0, `BCDU_OFF_STAT, 32'h0, q);
      n++;
    end
    if (n >= 30) n_mismatch++;
    rd(`BCDU_OFF_STAT, {20'h0, cyc, 8'h00}, 32'h00000F01);
  endtask : exec

  function automatic logic [11:0] ma(input logic [7:0] i);
    return `BCDU_MEM_BASE + {2'b00, i, 2'b00};
  endfunction : ma

  function automatic logic [7:0] bcd(input int v);
    return {4'(v / 10), 4'(v % 10)};
  endfunction : bcd

  // watcher: every answered read takes the oldest note
  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (notes.size() == 0) n_mismatch++;
      else begin
        nb = notes.pop_front();
        if (nb.mask != 32'h0) check(avs_readdata & nb.mask, nb.exp & nb.mask);
      end
    end
  end

  initial begin : watchdog
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    stop_test();
  end

  initial begin : main
    int a, b, r;
    logic [7:0] x, y, z, e;
    logic cy, hc, sb, co;
    logic [15:0] u;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(`BCDU_OFF_FLAGS, {24'h0, `BCDU_FLAGS_RST}, FULL);
    rd(`BCDU_OFF_SYM, {24'h0, `BCDU_SYM_RST}, FULL);
    rd(`BCDU_OFF_PEND, 32'h0, FULL);
    rd(`BCDU_OFF_STAT, 32'h0, FULL);
    // random bcd sums and differences; the adjusted byte must be the decimal answer
    wr(ma(8'h11), 32'h10);
    for (int k = 0; k < 24; k++) begin
      sb = k[0];
      a = $unsigned($random(seed)) % 100;
      b = $unsigned($random(seed)) % 100;
      x = bcd(a);
      y = bcd(b);
      if (!sb) begin
        {cy, z} = {1'b0, x} + {1'b0, y};
        hc = ({1'b0, x[3:0]} + {1'b0, y[3:0]}) > 5'hF;
        r = a + b;
      end else begin
        {cy, z} = {1'b0, x} - {1'b0, y};
        hc = x[3:0] < y[3:0];
        r = a - b + 100;
      end
      co = sb ? (r < 100) : (r >= 100);
      e = bcd(r % 100);
      wr(ma(8'h10), {24'h0, z});
      wr(`BCDU_OFF_FLAGS, {24'h0, cy, 3'b000, sb, hc, 2'b00});
      exec(k[1] ? `BCDU_OP_DA_P : `BCDU_OP_DA_R, k[1] ? 8'h11 : 8'h10, `BCDU_CYC_BYTE);
      rd(ma(8'h10), {24'h0, e}, FULL);
      rd(`BCDU_OFF_FLAGS, {24'h0, co, e == 8'h00, e[7], 1'b0, sb, hc, 2'b00}, 32'hEC);
    end
    rd(ma(8'h11), 32'h10, FULL);
    // byte decrement at the overflow, zero and wrap points
    wr(ma(8'h07), 32'h50);
    for (int k = 0; k < 4; k++) begin
      x = (k == 3) ? 8'($random(seed)) : dv[k];
      z = k[0] ? 8'h50 : 8'h30;
      wr(ma(z), {24'h0, x});
      wr(`BCDU_OFF_FLAGS, 32'h8C);
      exec(k[0] ? `BCDU_OP_DEC_P : `BCDU_OP_DEC_R, k[0] ? 8'h07 : 8'h30, `BCDU_CYC_BYTE);
      e = x - 8'h01;
      rd(ma(z), {24'h0, e}, FULL);
      rd(`BCDU_OFF_FLAGS, {24'h0, 1'b1, e == 8'h00, e[7], x == 8'h80, 2'b11, 2'b00}, 32'hFC);
    end
    rd(ma(8'h07), 32'h50, FULL);
    // word decrement: borrow must cross from low to high byte
    wr(ma(8'h09), 32'h30);
    for (int k = 0; k < 4; k++) begin
      z = k[0] ? 8'h30 : 8'h20;
      u = dw[k];
      wr(ma(z), {24'h0, u[15:8]});
      wr(ma(z + 8'h01), {24'h0, u[7:0]});
      wr(`BCDU_OFF_FLAGS, 32'h8C);
      exec(k[0] ? `BCDU_OP_WORD_MINUS_ONE_OP_P : `BCDU_OP_WORD_MINUS_ONE_OP_R, k[0] ? 8'h09 : 8'h20, `BCDU_CYC_WORD);
      u = dw[k] - 16'h0001;
      rd(ma(z), {24'h0, u[15:8]}, FULL);
      rd(ma(z + 8'h01), {24'h0, u[7:0]}, FULL);
      rd(`BCDU_OFF_FLAGS, {24'h0, 1'b1, u == 16'h0, u[15], dw[k] == 16'h8000, 4'hC}, 32'hFC);
    end
    // global disable: requests still latch, nothing is serviced until re-enabled
    wr(`BCDU_OFF_SYM, 32'h1);
    wr(`BCDU_OFF_FLAGS, 32'hAC);
    irq_req <= 8'h04;
    repeat (6) @(posedge clk_sys);
    check({31'h0, irq_service}, 32'h1);
    exec(`BCDU_OP_DI, 8'h00, `BCDU_CYC_DI);
    rd(`BCDU_OFF_SYM, 32'h0, 32'h1);
    rd(`BCDU_OFF_FLAGS, 32'hAC, 32'hFC);
    irq_req <= 8'h40;
    repeat (6) @(posedge clk_sys);
    check({31'h0, irq_service}, 32'h0);
    rd(`BCDU_OFF_PEND, 32'h44, 32'hFF);
    wr(`BCDU_OFF_SYM, 32'h1);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq_service}, 32'h1);
    // mask all before touching pending bits, then re-enable with nothing pending
    exec(`BCDU_OP_DI, 8'h00, `BCDU_CYC_DI);
    wr(`BCDU_OFF_PEND, 32'h44);
    wr(`BCDU_OFF_SYM, 32'h1);
    repeat (3) @(posedge clk_sys);
    check({31'h0, irq_service}, 32'h0);
    rd(`BCDU_OFF_PEND, 32'h0, 32'hFF);
    // unmapped place reads zero and ignores writes; CMD write without both low byte lanes is ignored; unknown opcode sets sticky bit but does not run
    wr(12'h3F0, 32'($random(seed)));
    rd(12'h3F0, 32'h0, FULL);
    avs_byteenable <= 4'h1;
    wr(`BCDU_OFF_CMD, 32'h00FF);
    avs_byteenable <= 4'hF;
    rd(`BCDU_OFF_STAT, 32'h0, 32'h3);
    rd(`BCDU_OFF_CMD, 32'h008F, FULL);
    wr(`BCDU_OFF_CMD, 32'h00FF);
    rd(`BCDU_OFF_STAT, 32'h2, 32'h3);
    wr(`BCDU_OFF_STAT, 32'h2);
    rd(`BCDU_OFF_STAT, 32'h0, 32'h3);
    repeat (2) @(posedge clk_sys);
    if (notes.size() != 0) n_mismatch++;
    stop_test();
  end
endmodule : bcdu_tb_top
